// *** spe_pkg.sv ***
// Package for the serial programming entry block: states, key, field sizes.
// Assumes a 100 MHz system clock sampling the programmer's pins.
package spe_pkg;

  // Entry key width and expected pattern (pattern value is arbitrary)
  localparam int          SPE_KEY_BITS   = 32;
  localparam logic [31:0] SPE_KEY_VALUE  = 32'hA5C3_3C5A;
  // Reset values
  localparam logic        SPE_LVE_RESET  = 1'b1;
  localparam logic [1:0]  SPE_SYNC_RESET = 2'h0;
  // Master clear idles high, so its synchroniser resets to released
  localparam logic [1:0]  SPE_MC_SYNC_RESET = 2'h3;
  // Serial command framing: 8-bit command, 16-bit payload
  localparam int          SPE_CMD_BITS   = 8;
  localparam int          SPE_DATA_BITS  = 16;
  // Buffer depth of the received-word buffer
  localparam int          SPE_BUF_DEPTH  = 2;

  typedef enum logic [2:0] {
    SPE_ST_RUN,
    SPE_ST_KEY,
    SPE_ST_PV_HV,
    SPE_ST_PV_LV
  } spe_state_t;

  // Decoded command codes
  localparam logic [7:0] SPE_CMD_WR_PROG = 8'h01;
  localparam logic [7:0] SPE_CMD_WR_UID  = 8'h02;
  localparam logic [7:0] SPE_CMD_WR_CFG  = 8'h03;
  localparam logic [7:0] SPE_CMD_READ    = 8'h04;

  // Destination kinds for received writes
  typedef enum logic [1:0] {
    SPE_DST_PROG,
    SPE_DST_UID,
    SPE_DST_CFG
  } spe_dst_t;

endpackage

// *** spe_buf.sv ***
// Two-entry buffer carrying received write words to the memory side.
// Assumes a single clock; the drain side may stall at any time.
`timescale 1ns/1ns
module spe_buf
  import spe_pkg::*;
#(
  parameter int WIDTH = 26,
  parameter int DEPTH = SPE_BUF_DEPTH
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             clk_en_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);

  initial begin
    if (DEPTH != 2) $error("spe_buf supports only a depth of two");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wp;
    logic                  rp;
    logic [1:0]            cnt;
  } spe_buf_st_t;

  spe_buf_st_t s_q;
  spe_buf_st_t s_d;
  logic        push;
  logic        pop;

  // Honest full and empty from the occupancy count
  assign wr_ready_out = (s_q.cnt != 2'h2);
  assign rd_valid_out = (s_q.cnt != 2'h0);
  assign rd_data_out  = s_q.mem[s_q.rp];
  assign push = wr_valid_in && wr_ready_out;
  assign pop  = rd_valid_out && rd_ready_in;

  // Pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = wr_data_in;
      s_d.wp = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    case ({push, pop})
      2'b10:   s_d.cnt = s_q.cnt + 2'h1;
      2'b01:   s_d.cnt = s_q.cnt - 2'h1;
      default: s_d.cnt = s_q.cnt;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

endmodule

// *** spe_top.sv ***
// Entry and pin framing for the in-circuit serial port.
// Assumes the programmer's clock, data and master-clear pins arrive
// asynchronously and are sampled by the 100 MHz system clock.
`timescale 1ns/1ns

module spe_top
  import spe_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  input  wire logic        prog_serial_clock_in,
  input  wire logic        prog_serial_data_in,
  output logic             prog_serial_data_out,
  output logic             prog_serial_data_oe_out,
  input  wire logic        master_clear_pin_n_in,
  input  wire logic        high_voltage_in,
  input  wire logic        mc_reset_cfg_in,
  input  wire logic [15:0] read_data_in,
  output logic             low_voltage_entry_enable_out,
  output logic             mc_reset_enable_out,
  output logic             device_reset_out,
  output logic             prog_mode_out,
  output logic             hv_session_out,
  output logic             wr_valid_out,
  input  wire logic        wr_ready_in,
  output logic [1:0]       wr_dst_out,
  output logic [7:0]       wr_cmd_out,
  output logic [15:0]      wr_data_out,
  output logic             lve_change_reject_out
);

  localparam int FW = SPE_CMD_BITS + SPE_DATA_BITS;

  initial begin
    if (SPE_KEY_BITS != 32) $error("Entry key must be 32 bits");
  end

  typedef struct packed {
    logic [1:0]        clk_sy;
    logic [1:0]        dat_sy;
    logic [1:0]        mc_sy;
    logic [1:0]        hv_sy;
    logic              clk_prev;
    spe_state_t        st;
    logic [31:0]       key_sh;
    logic [5:0]        bit_cnt;
    logic              key_lock;
    logic [FW-1:0]     frm_sh;
    logic              lve;
    logic              reject;
    logic              push;
    logic [FW+1:0]     push_word;
    logic              drive;
    logic [15:0]       rd_sh;
    logic [4:0]        rd_cnt;
    logic              dout;
  } spe_st_t;

  spe_st_t s_q;
  spe_st_t s_d;

  logic          clk_s;
  logic          dat_s;
  logic          mc_low;
  logic          hv_s;
  logic          rise;
  logic          fall;
  logic          in_pv;
  logic          buf_ready;
  logic          buf_valid;
  logic [FW+1:0] buf_data;

  // Second synchroniser stages are the only pin views logic may read
  assign clk_s    = s_q.clk_sy[1];
  assign dat_s    = s_q.dat_sy[1];
  assign mc_low   = ~s_q.mc_sy[1];
  assign hv_s     = s_q.hv_sy[1];
  assign rise     = clk_s && !s_q.clk_prev;
  assign fall     = !clk_s && s_q.clk_prev;
  assign in_pv    = (s_q.st == SPE_ST_PV_HV) || (s_q.st == SPE_ST_PV_LV);

  // Entry, key shifting and serial framing
  always_comb begin
    s_d = s_q;
    s_d.clk_sy  = {s_q.clk_sy[0], prog_serial_clock_in};
    s_d.dat_sy  = {s_q.dat_sy[0], prog_serial_data_in};
    s_d.mc_sy   = {s_q.mc_sy[0], master_clear_pin_n_in};
    s_d.hv_sy   = {s_q.hv_sy[0], high_voltage_in};
    s_d.clk_prev = clk_s;
    s_d.reject = 1'b0;
    // Push holds until the buffer takes the word; a frame that ends meanwhile is dropped
    if (s_q.push && buf_ready) begin
      s_d.push = 1'b0;
    end
    case (s_q.st)
      SPE_ST_RUN: begin
        s_d.bit_cnt = 6'h00;
        s_d.frm_sh  = '0;
        // A failed key stays locked out until master clear is released
        if (!mc_low) begin
          s_d.key_lock = 1'b0;
        end
        // High voltage only counts with clock and data held low
        if (hv_s && !clk_s && !dat_s) begin
          s_d.st = SPE_ST_PV_HV;
        end else if (mc_low && s_q.lve && !s_q.key_lock) begin
          s_d.st = SPE_ST_KEY;
          s_d.key_sh = '0;
        end
      end
      SPE_ST_KEY: begin
        if (!mc_low || !s_q.lve) begin
          s_d.st = SPE_ST_RUN;
        end else if (rise) begin
          s_d.key_sh  = {s_q.key_sh[30:0], dat_s};
          s_d.bit_cnt = s_q.bit_cnt + 6'h01;
          if (s_q.bit_cnt == 6'(SPE_KEY_BITS - 1)) begin
            // Exact match only; a wrong key needs a fresh master clear
            if ({s_q.key_sh[30:0], dat_s} == SPE_KEY_VALUE) begin
              s_d.st = SPE_ST_PV_LV;
            end else begin
              s_d.st = SPE_ST_RUN;
              s_d.key_lock = 1'b1;
            end
            s_d.bit_cnt = 6'h00;
          end
        end
      end
      SPE_ST_PV_HV, SPE_ST_PV_LV: begin
        if (rise && !s_q.drive) begin
          s_d.frm_sh  = {s_q.frm_sh[FW-2:0], dat_s};
          s_d.bit_cnt = s_q.bit_cnt + 6'h01;
          if (s_q.bit_cnt == 6'(SPE_CMD_BITS - 1) &&
              {s_q.frm_sh[6:0], dat_s} == SPE_CMD_READ) begin
            // Read command: turn the data pin round and shift out
            s_d.drive   = 1'b1;
            s_d.rd_sh   = read_data_in;
            s_d.rd_cnt  = 5'h00;
            s_d.bit_cnt = 6'h00;
          end else if (s_q.bit_cnt == 6'(FW - 1)) begin
            s_d.bit_cnt = 6'h00;
            if (s_q.frm_sh[FW-2:FW-9] == SPE_CMD_WR_CFG &&
                s_q.lve && !s_q.frm_sh[0] && !dat_s) begin
              // Clearing the entry enable is a high-voltage privilege
              if (s_q.st == SPE_ST_PV_HV) begin
                s_d.lve = 1'b0;
              end else begin
                s_d.reject = 1'b1;
              end
            end
            // Write words are dropped while an earlier push is still pending
            if (!s_q.push) begin
              s_d.push = 1'b1;
              s_d.push_word = {2'(
                (s_q.frm_sh[FW-2:FW-9] == SPE_CMD_WR_CFG) ? SPE_DST_CFG :
                (s_q.frm_sh[FW-2:FW-9] == SPE_CMD_WR_UID) ? SPE_DST_UID :
                SPE_DST_PROG), s_q.frm_sh[FW-2:0], dat_s};
            end
          end
        end
        // Data changes on falling edges, stable for the sampling edge
        if (s_q.drive && fall) begin
          s_d.dout   = s_q.rd_sh[15];
          s_d.rd_sh  = {s_q.rd_sh[14:0], 1'b0};
          s_d.rd_cnt = s_q.rd_cnt + 5'h01;
          if (s_q.rd_cnt == 5'(SPE_DATA_BITS)) begin
            s_d.drive = 1'b0;
            s_d.dout  = 1'b0;
          end
        end
        // Releasing master clear ends a low-voltage session; dropping high voltage ends a high-voltage one
        if (s_q.st == SPE_ST_PV_LV && !mc_low) begin
          s_d.st = SPE_ST_RUN;
        end
        if (s_q.st == SPE_ST_PV_HV && !hv_s) begin
          s_d.st = SPE_ST_RUN;
        end
        if (s_d.st == SPE_ST_RUN) begin
          s_d.drive = 1'b0;
          s_d.dout  = 1'b0;
        end
      end
      default: s_d.st = SPE_ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q     <= '0;
      s_q.lve <= SPE_LVE_RESET;
      s_q.st  <= SPE_ST_RUN;
      // Avoids a false master-clear low while the synchroniser fills
      s_q.mc_sy <= SPE_MC_SYNC_RESET;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  // Received write words pass a two-entry buffer to the memory side
  spe_buf #(
    .WIDTH (FW + 2),
    .DEPTH (SPE_BUF_DEPTH)
  ) u_buf (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .clk_en_in    (clk_en_in),
    .wr_valid_in  (s_q.push),
    .wr_ready_out (buf_ready),
    .wr_data_in   (s_q.push_word),
    .rd_valid_out (buf_valid),
    .rd_ready_in  (wr_ready_in),
    .rd_data_out  (buf_data)
  );

  assign wr_valid_out = buf_valid;
  assign wr_dst_out   = buf_data[FW+1:FW];
  assign wr_cmd_out   = buf_data[FW-1:SPE_DATA_BITS];
  assign wr_data_out  = buf_data[SPE_DATA_BITS-1:0];

  // Pin and status outputs
  assign prog_serial_data_out    = s_q.dout;
  assign prog_serial_data_oe_out = s_q.drive;
  assign low_voltage_entry_enable_out = s_q.lve;
  // Entry enable overrides the configuration's reset disable
  assign mc_reset_enable_out = s_q.lve || mc_reset_cfg_in;
  assign device_reset_out = mc_reset_enable_out && mc_low && !in_pv;
  assign prog_mode_out    = in_pv;
  assign hv_session_out   = (s_q.st == SPE_ST_PV_HV);
  assign lve_change_reject_out = s_q.reject;

endmodule

// *** spe_top_sva.sv ***
// Checker for the serial programming entry block, watching top ports.
// Assumes the bind below attaches it to every instance of the top.
`timescale 1ns/1ns
module spe_top_sva (
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic        mc_reset_cfg_in,
  input wire logic        master_clear_pin_n_in,
  input wire logic        wr_ready_in,
  input wire logic        prog_serial_data_oe_out,
  input wire logic        low_voltage_entry_enable_out,
  input wire logic        mc_reset_enable_out,
  input wire logic        device_reset_out,
  input wire logic        prog_mode_out,
  input wire logic        hv_session_out,
  input wire logic        wr_valid_out,
  input wire logic [15:0] wr_data_out,
  input wire logic        lve_change_reject_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Reset function is forced on whenever entry is enabled
  a_rst_en_forced: assert property (
    mc_reset_enable_out ==
    (low_voltage_entry_enable_out || mc_reset_cfg_in))
    else $error("reset enable does not follow entry enable");
  // A session never resets the core under it
  a_mode_no_reset: assert property (prog_mode_out |-> !device_reset_out)
    else $error("device reset during program mode");
  a_hv_in_mode: assert property (hv_session_out |-> prog_mode_out)
    else $error("high voltage session outside program mode");
  a_lv_needs_en: assert property (
    $rose(prog_mode_out) && !hv_session_out
    |-> low_voltage_entry_enable_out)
    else $error("low voltage entry while disabled");
  // Sync delay of the pin plus state update fits in six cycles
  a_lv_exit_bound: assert property (
    prog_mode_out && !hv_session_out &&
    master_clear_pin_n_in |-> ##[1:6] !prog_mode_out)
    else $error("low voltage session outlived master clear release");
  a_lve_clear_hv: assert property (
    $fell(low_voltage_entry_enable_out)
    |-> $past(hv_session_out))
    else $error("entry enable cleared outside high voltage session");
  a_reject_in_lv: assert property (
    lve_change_reject_out |->
    prog_mode_out && !hv_session_out && low_voltage_entry_enable_out)
    else $error("reject pulse outside low voltage session");
  a_wr_word_hold: assert property (
    wr_valid_out && !wr_ready_in |=>
    wr_valid_out && $stable(wr_data_out))
    else $error("stalled write word changed or vanished");
  a_oe_in_mode: assert property (prog_serial_data_oe_out |-> prog_mode_out)
    else $error("data pin driven outside program mode");
  c_lv_entry: cover property ($rose(prog_mode_out) && !hv_session_out);
  c_hv_entry: cover property ($rose(hv_session_out));
  c_wr_stall: cover property ((wr_valid_out && !wr_ready_in) [*3]);
  c_reject: cover property (lve_change_reject_out);
endmodule

bind spe_top spe_top_sva chk (.sys_clk_in, .rst_n_in, .mc_reset_cfg_in,
  .master_clear_pin_n_in, .wr_ready_in, .prog_serial_data_oe_out,
  .low_voltage_entry_enable_out, .mc_reset_enable_out, .device_reset_out,
  .prog_mode_out, .hv_session_out, .wr_valid_out, .wr_data_out,
  .lve_change_reject_out);

// *** spe_prog.sv ***
// Programmer model: drives serial clock, data, master clear, high voltage.
// Assumes an 80 ns serial clock that stands low between frames.
`timescale 1ns/1ns
module spe_prog (
  input  wire logic dev_dat_in,
  input  wire logic dev_oe_in,
  output logic      sclk_out,
  output logic      line_out,
  output logic      mc_n_out,
  output logic      hv_out
);
  logic pd = 1'b0;
  logic pen = 1'b0;
  initial begin
    sclk_out = 1'b0;
    mc_n_out = 1'b1;
    hv_out = 1'b0;
  end
  // No pull on the line: once released it shows the inverse of the last bit
  assign line_out = dev_oe_in ? dev_dat_in : (pen ? pd : ~pd);
  // MSB first, data set while clock is low
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      pen = 1'b1;
      pd = v[i];
      #40 sclk_out = 1'b1;
      #40 sclk_out = 1'b0;
    end
    pen = 1'b0;
  endtask
  // Device changes data on falls; the command's last fall brings the
  // first bit, so sample late in each high phase, just before the fall.
  // Exactly 16 clocks: a 17th rise would be taken as a frame bit.
  task automatic read16(output logic [15:0] r);
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      #40 sclk_out = 1'b1;
      #35 r = {r[14:0], line_out};
      #5 sclk_out = 1'b0;
    end
  endtask
  task automatic lv_enter(input logic [31:0] k);
    mc_n_out = 1'b0;
    #200 shift(k, 32);
  endtask
  task automatic lv_leave();
    mc_n_out = 1'b1;
  endtask
  task automatic hv_enter();
    pen = 1'b1;
    pd = 1'b0;
    sclk_out = 1'b0;
    #200 hv_out = 1'b1;
    #200;
  endtask
  task automatic hv_leave();
    hv_out = 1'b0;
    pen = 1'b0;
  endtask
endmodule

// *** tb.sv ***
// Testbench for the serial programming entry block.
// Assumes the programmer model drives the pins and the bench the rest.
`timescale 1ns/1ns
module tb;
  import spe_pkg::*;
  logic sys_clk_in = 0, rst_n_in = 0, clk_en_in = 1, mc_reset_cfg_in = 0;
  logic wr_ready_in = 0, prog_serial_data_out, prog_serial_data_oe_out;
  logic [15:0] read_data_in = 16'h0000, wr_data_out, r;
  logic low_voltage_entry_enable_out, mc_reset_enable_out, wr_valid_out;
  logic device_reset_out, prog_mode_out, hv_session_out;
  logic lve_change_reject_out;
  logic [1:0] wr_dst_out;
  logic [7:0] wr_cmd_out;
  wire logic prog_serial_clock_in, prog_serial_data_in;
  wire logic master_clear_pin_n_in, high_voltage_in;
  int bad_count = 0, checks_done = 0, cycles = 0, rej_count = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  // Count reject pulses mid-cycle, away from the edge that launches them
  always @(negedge sys_clk_in) begin
    if (lve_change_reject_out === 1'b1) rej_count++;
  end
  spe_top dut (.sys_clk_in, .rst_n_in, .clk_en_in, .prog_serial_clock_in,
    .prog_serial_data_in, .prog_serial_data_out, .prog_serial_data_oe_out,
    .master_clear_pin_n_in, .high_voltage_in, .mc_reset_cfg_in,
    .read_data_in, .low_voltage_entry_enable_out, .mc_reset_enable_out,
    .device_reset_out, .prog_mode_out, .hv_session_out, .wr_valid_out,
    .wr_ready_in, .wr_dst_out, .wr_cmd_out, .wr_data_out,
    .lve_change_reject_out);
  spe_prog prog (.dev_dat_in(prog_serial_data_out),
    .dev_oe_in(prog_serial_data_oe_out), .sclk_out(prog_serial_clock_in),
    .line_out(prog_serial_data_in), .mc_n_out(master_clear_pin_n_in),
    .hv_out(high_voltage_in));
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // Wait for a word, compare it, then accept it with one ready cycle
  task automatic take(input logic [1:0] d, input logic [7:0] c,
                      input logic [15:0] v);
    int i;
    i = 0;
    while (wr_valid_out !== 1'b1 && i < 60) begin
      cyc(1);
      i++;
    end
    chk(wr_valid_out === 1'b1 && wr_dst_out === d && wr_cmd_out === c &&
        wr_data_out === v, "write word mismatch");
    wr_ready_in = 1'b1;
    cyc(1);
    wr_ready_in = 1'b0;
  endtask
  task automatic t_lv_session();
    prog.lv_enter(SPE_KEY_VALUE);
    cyc(8);
    chk(prog_mode_out === 1'b1 && hv_session_out === 1'b0, "no lv entry");
    prog.shift({8'h01, 16'h1234}, 24);
    take(2'h0, SPE_CMD_WR_PROG, 16'h1234);
    prog.shift({8'h02, 16'hABCD}, 24);
    cyc(30);
    chk(wr_valid_out === 1'b1 && wr_data_out === 16'hABCD, "stall lost");
    take(2'h1, SPE_CMD_WR_UID, 16'hABCD);
    prog.shift({8'h03, 16'h0000}, 24);
    wr_ready_in = 1'b1;
    cyc(10);
    wr_ready_in = 1'b0;
    chk(low_voltage_entry_enable_out === 1'b1, "lv cleared enable");
    chk(rej_count == 1, "no reject pulse in lv session");
    prog.lv_leave();
    cyc(8);
    chk(prog_mode_out === 1'b0, "lv session held");
  endtask
  task automatic t_bad_key();
    prog.lv_enter(SPE_KEY_VALUE ^ 32'h0000_0001);
    cyc(8);
    chk(prog_mode_out === 1'b0 && device_reset_out === 1'b1, "bad key");
    prog.shift(SPE_KEY_VALUE, 32);
    cyc(8);
    chk(prog_mode_out === 1'b0, "key retried without release");
    prog.lv_leave();
    cyc(8);
  endtask
  task automatic t_hv_session();
    prog.hv_enter();
    cyc(8);
    chk(prog_mode_out === 1'b1 && hv_session_out === 1'b1, "no hv");
    read_data_in = 16'hC3A5;
    prog.shift(32'h0000_0004, 8);
    prog.read16(r);
    cyc(5);
    chk(r === 16'hC3A5 && prog_serial_data_oe_out === 1'b0, "read");
    prog.shift({8'h03, 16'h0000}, 24);
    take(2'h2, SPE_CMD_WR_CFG, 16'h0000);
    cyc(4);
    chk(low_voltage_entry_enable_out === 1'b0, "hv clear");
    chk(rej_count == 1, "reject pulse in hv session");
    chk(mc_reset_enable_out === 1'b0, "reset enable stuck");
    mc_reset_cfg_in = 1'b1;
    cyc(1);
    chk(mc_reset_enable_out === 1'b1, "cfg reset enable");
    prog.hv_leave();
    cyc(8);
    chk(prog_mode_out === 1'b0, "hv session held");
    prog.lv_enter(SPE_KEY_VALUE);
    cyc(8);
    chk(prog_mode_out === 1'b0, "lv entry while disabled");
    prog.lv_leave();
    cyc(8);
  endtask
  task automatic give_verdict();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cycle ceiling well above the few thousand cycles the run needs
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    cyc(2);
    rst_n_in = 1'b1;
    cyc(4);
    chk(low_voltage_entry_enable_out === 1'b1 &&
        mc_reset_enable_out === 1'b1, "reset values");
    t_lv_session();
    t_bad_key();
    t_hv_session();
    give_verdict();
  end
endmodule
